// ---- dual_channel_power_alarm_regs.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - gain code 0x3 gives 2, 0xF gives 8
// - gain zero uses strap: ground 8, supply 2
// - alarm asserts when either channel exceeds threshold
// - trip point is threshold code plus one
// - config bits 1:0 pick 10 or 15 percent, other codes no hysteresis
// - alert asserts when warning counter saturates
// - config bit 2 masks that alert source
// - reset loads default thresholds and configuration
// - readings valid one update after power-up
// - bus address is 0x08 plus strap pair
// - 8-bit power sample in read-only register
// - combined registers access both channels at once
// - warning level is three quarters of threshold
// - warning counter clears when read
// - last get value kept read-only
// - status copy kept from last status read
// - thresholds reset to 0xE6, master writable
// - configs reset 0x03, combined reads 0x33
// - power readings at 0x09/0x0A, read-only
// - one converter alternates channels every half period
module dual_channel_power_alarm_regs
    import power_alarm_pkg::*;
#(
    parameter int PWRUP_CYCLES = power_alarm_pkg::PWRUP_CYC,
    parameter int UPDATE_CYCLES = power_alarm_pkg::UPDATE_CYC,
    parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3c,   // arbitrary value
    parameter logic [7:0] REV_CODE = 8'h01     // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic vclk,
    input wire logic vdio_in,
    output logic vdio_out,
    output logic vdio_oe,
    output logic alert_out,
    output logic alert_oe,
    output logic alarm_out,
    output logic alarm_oe,
    input wire logic [1:0] addr_strap,
    input wire logic [1:0] gain_strap_pin,
    output logic [1:0] gain_is_x8,
    output power_alarm_pkg::adc_req_s adc_req,
    input wire power_alarm_pkg::adc_res_s adc_res
);
    import power_alarm_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync_a, sync_b;
    logic vclk_d, vclk_s, vdio_s, vclk_rise, vclk_fall;
    logic [1:0] addr_s, gstrap_s;

    always_ff @(posedge mclk) begin
        sync_a <= {gain_strap_pin, addr_strap, vdio_in, vclk};
        sync_b <= sync_a;
        vclk_d <= sync_b[0];
    end

    assign vclk_s = sync_b[0];
    assign vdio_s = sync_b[1];
    assign addr_s = sync_b[3:2];
    assign gstrap_s = sync_b[5:4];
    assign vclk_rise = vclk_s & ~vclk_d;
    assign vclk_fall = ~vclk_s & vclk_d;

    // ------------------------------------------------------------
    // registers and shared state
    // ------------------------------------------------------------
    logic [7:0] gain_select_chan [2];
    logic [7:0] trip_threshold_chan [2];
    logic [7:0] trip_config_chan [2];
    logic [7:0] power_reading_chan [2];
    logic [7:0] warn_level_chan [2];
    logic [7:0] warn_counter_chan [2];
    logic [1:0] alarm_chan, count_clear, alert_src;
    logic [7:0] last_get_value;
    logic [7:0] status_snapshot;
    logic [7:0] consolidated_status;
    logic readings_valid, wr_en, rd_en;
    logic [7:0] reg_idx, wr_data, rd_data;
    logic rd_hit;

    // ------------------------------------------------------------
    // power-up and sample sequencer
    // ------------------------------------------------------------
    logic [31:0] pwr_cnt;
    logic [31:0] tick_cnt;
    logic next_chan;

    // readings stay hidden until power-up plus one full update period
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_cnt <= 32'h0;
            readings_valid <= 1'b0;
        end else if (pwr_cnt == 32'(PWRUP_CYCLES + UPDATE_CYCLES - 1)) begin
            readings_valid <= 1'b1;
        end else begin
            pwr_cnt <= pwr_cnt + 32'h1;
        end
    end

    // two conversions per period, so each channel sees one per period
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_cnt <= 32'h0;
            next_chan <= 1'b0;
            adc_req <= '0;
        end else if (tick_cnt == 32'(UPDATE_CYCLES / 2 - 1)) begin
            tick_cnt <= 32'h0;
            adc_req.start <= 1'b1;
            adc_req.chan <= next_chan;
            next_chan <= ~next_chan;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
            adc_req.start <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // per-channel measurement, alarm and warning logic
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [7:0] hyst;
        logic [9:0] th_x3;
        logic new_sample;
        logic [3:0] gcode;

        assign gcode = gain_select_chan[c][3:0];
        assign th_x3 = {2'b00, trip_threshold_chan[c]} * 10'd3;
        assign warn_level_chan[c] = th_x3[9:2];
        assign new_sample = adc_res.done & (adc_res.chan == 1'(c));

        always_comb begin
            unique case (trip_config_chan[c][1:0])
                HYST_10: hyst = trip_threshold_chan[c] / 8'd10;
                HYST_15: hyst = 8'(th_x3 / 10'd20);
                default: hyst = 8'h00;
            endcase
        end

        always_ff @(posedge mclk) begin
            if (rst) begin
                power_reading_chan[c] <= ZERO8;
            end else if (new_sample) begin
                power_reading_chan[c] <= adc_res.code;
            end
        end

        // trip above code N means power reached N + 1
        always_ff @(posedge mclk) begin
            if (rst || !readings_valid) begin
                alarm_chan[c] <= 1'b0;
            end else if (power_reading_chan[c] > trip_threshold_chan[c]) begin
                alarm_chan[c] <= 1'b1;
            end else if (power_reading_chan[c] <
                         trip_threshold_chan[c] - hyst) begin
                alarm_chan[c] <= 1'b0;
            end
        end

        // an increment in the clearing cycle survives as a count of one
        always_ff @(posedge mclk) begin
            if (rst) begin
                warn_counter_chan[c] <= ZERO8;
            end else if (new_sample && readings_valid &&
                         adc_res.code > warn_level_chan[c]) begin
                if (count_clear[c]) begin
                    warn_counter_chan[c] <= 8'h01;
                end else if (warn_counter_chan[c] != WARN_MAX) begin
                    warn_counter_chan[c] <= warn_counter_chan[c] + 8'h01;
                end
            end else if (count_clear[c]) begin
                warn_counter_chan[c] <= ZERO8;
            end
        end

        assign alert_src[c] = (warn_counter_chan[c] == WARN_MAX) &&
                              !trip_config_chan[c][CFG_ALERT_MASK];

        // a zero code falls back to the strap; 0xF fixes gain 8, other codes fix gain 2
        always_comb begin
            if (gcode == GAIN_CODE_X8) begin
                gain_is_x8[c] = 1'b1;
            end else if (gcode == GAIN_CODE_X2) begin
                gain_is_x8[c] = 1'b0;
            end else if (gcode == 4'h0) begin
                gain_is_x8[c] = ~gstrap_s[c];
            end else begin
                gain_is_x8[c] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // open-drain outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            alarm_oe <= 1'b0;
            alert_oe <= 1'b0;
        end else begin
            alarm_oe <= |alarm_chan;
            alert_oe <= |alert_src;
        end
    end

    assign alarm_out = 1'b0;
    assign alert_out = 1'b0;

    always_comb begin
        consolidated_status = ZERO8;
        consolidated_status[ST_ALARM1] = alarm_chan[0];
        consolidated_status[ST_ALARM2] = alarm_chan[1];
        consolidated_status[ST_ALERT] = |alert_src;
        consolidated_status[ST_VALID] = readings_valid;
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                gain_select_chan[i] <= RST_GAIN;
                trip_threshold_chan[i] <= RST_THRESH;
                trip_config_chan[i] <= RST_CFG;
            end
        end else if (wr_en) begin
            unique case (reg_idx)
                OFS_GAIN_CH1: gain_select_chan[0] <= wr_data;
                OFS_GAIN_CH2: gain_select_chan[1] <= wr_data;
                OFS_THRESH_CH1: trip_threshold_chan[0] <= wr_data;
                OFS_THRESH_CH2: trip_threshold_chan[1] <= wr_data;
                OFS_CFG_CH1: trip_config_chan[0] <= wr_data;
                OFS_CFG_CH2: trip_config_chan[1] <= wr_data;
                OFS_GAIN_BOTH: begin
                    gain_select_chan[0] <= {4'h0, wr_data[3:0]};
                    gain_select_chan[1] <= {4'h0, wr_data[7:4]};
                end
                OFS_CFG_BOTH: begin
                    trip_config_chan[0] <= {4'h0, wr_data[3:0]};
                    trip_config_chan[1] <= {4'h0, wr_data[7:4]};
                end
                default: ;  // read-only and unmapped writes are dropped
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        unique case (reg_idx)
            OFS_MAKER: rd_data = MAKER_CODE;
            OFS_PART: rd_data = PART_CODE;
            OFS_REV: rd_data = REV_CODE;
            OFS_PROTO: rd_data = VAL_PROTO;
            OFS_CAPS: rd_data = VAL_CAPS;
            OFS_GAIN_CH1: rd_data = gain_select_chan[0];
            OFS_GAIN_CH2: rd_data = gain_select_chan[1];
            OFS_POWER_READING_CH1:
                rd_data = readings_valid ? power_reading_chan[0] : ZERO8;
            OFS_POWER_READING_CH2:
                rd_data = readings_valid ? power_reading_chan[1] : ZERO8;
            OFS_THRESH_CH1: rd_data = trip_threshold_chan[0];
            OFS_THRESH_CH2: rd_data = trip_threshold_chan[1];
            OFS_CFG_CH1: rd_data = trip_config_chan[0];
            OFS_CFG_CH2: rd_data = trip_config_chan[1];
            OFS_STATUS: rd_data = consolidated_status;
            OFS_LAST_GET: rd_data = last_get_value;
            OFS_STATUS_SNAP: rd_data = status_snapshot;
            OFS_WLVL_CH1: rd_data = warn_level_chan[0];
            OFS_WLVL_CH2: rd_data = warn_level_chan[1];
            OFS_WCNT_CH1: rd_data = warn_counter_chan[0];
            OFS_WCNT_CH2: rd_data = warn_counter_chan[1];
            OFS_GAIN_BOTH:
                rd_data = {gain_select_chan[1][3:0],
                           gain_select_chan[0][3:0]};
            OFS_CFG_BOTH:
                rd_data = {trip_config_chan[1][3:0],
                           trip_config_chan[0][3:0]};
            default: begin
                rd_data = ZERO8;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign count_clear[0] = rd_en && (reg_idx == OFS_WCNT_CH1);
    assign count_clear[1] = rd_en && (reg_idx == OFS_WCNT_CH2);

    always_ff @(posedge mclk) begin
        if (rst) begin
            last_get_value <= ZERO8;
            status_snapshot <= ZERO8;
        end else if (rd_en) begin
            last_get_value <= rd_data;
            if (reg_idx == OFS_STATUS) begin
                status_snapshot <= consolidated_status;
            end
        end
    end

    // ------------------------------------------------------------
    // serial link slave
    // ------------------------------------------------------------
    link_state_e state;
    logic [4:0] bit_cnt;
    logic [12:0] hdr;
    logic [7:0] shreg;
    logic addressed;
    logic is_get;
    logic [12:0] hdr_next;

    assign hdr_next = {hdr[11:0], vdio_s};
    assign reg_idx = (state == ST_HDR) ? hdr_next[7:0] : hdr[7:0];
    assign wr_en = (state == ST_DATA) && vclk_rise &&
                   (bit_cnt == BYTE_BITS - 5'd1) && addressed;
    assign rd_en = (state == ST_HDR) && vclk_rise &&
                   (bit_cnt == HDR_BITS - 5'd1) &&
                   (hdr_next[12:9] == BASE_ADDR + {2'b00, addr_s}) &&
                   hdr_next[8];
    assign wr_data = {shreg[6:0], vdio_s};

    // device drives on falling vclk, master samples on rising vclk
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            bit_cnt <= 5'd0;
            hdr <= 13'h0;
            shreg <= ZERO8;
            addressed <= 1'b0;
            is_get <= 1'b0;
            vdio_oe <= 1'b0;
            vdio_out <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    vdio_oe <= 1'b0;
                    if (vclk_rise && !vdio_s) begin
                        state <= ST_HDR;
                        bit_cnt <= 5'd0;
                    end
                end
                ST_HDR: if (vclk_rise) begin
                    hdr <= hdr_next;
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == HDR_BITS - 5'd1) begin
                        bit_cnt <= 5'd0;
                        addressed <= hdr_next[12:9] ==
                                     BASE_ADDR + {2'b00, addr_s};
                        is_get <= hdr_next[8];
                        if (hdr_next[8]) begin
                            shreg <= rd_data;
                            state <= ST_RESP;
                        end else begin
                            state <= ST_DATA;
                        end
                    end
                end
                ST_DATA: if (vclk_rise) begin
                    shreg <= wr_data;
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == BYTE_BITS - 5'd1) begin
                        bit_cnt <= 5'd0;
                        // ack low for a mapped register, high otherwise
                        shreg <= {~rd_hit, 7'h0};
                        state <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (vclk_fall) begin
                        vdio_oe <= addressed;
                        vdio_out <= shreg[7];
                    end
                    if (vclk_rise && vdio_oe) begin
                        shreg <= {shreg[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 5'd1;
                        if (bit_cnt == (is_get ? BYTE_BITS : ACK_BITS)
                                       - 5'd1) begin
                            state <= ST_IDLE;
                            vdio_oe <= 1'b0;
                        end
                    end else if (vclk_rise && !addressed) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule : dual_channel_power_alarm_regs

// ---- link_master.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// link master model
// ------------------------------------------------------------
module link_master (
    input wire logic vdio_out,
    input wire logic vdio_oe,
    output logic vclk,
    output wire logic vdio_line
);
    logic drv_en = 1'b0;
    logic drv_bit = 1'b1;
    initial vclk = 1'b0;
    // pulled-up wire: a released line reads high
    assign vdio_line = vdio_oe ? vdio_out : (drv_en ? drv_bit : 1'b1);
    // clock stands low between frames; an idle rise closes each frame
    task automatic xfer(input logic [3:0] a, input logic g,
        input logic [7:0] idx, input logic [7:0] wd,
        output logic [7:0] rd);
        logic [21:0] bits;
        int n;
        int m;
        bits = {1'b0, a, g, idx, wd};
        n = g ? 14 : 22;
        m = g ? 22 : 23;
        rd = 8'h00;
        for (int i = 0; i <= m; i++) begin
            drv_en = (i < n);
            drv_bit = (i < 22) ? bits[21 - i] : 1'b1;
            #24 vclk = 1'b1;
            if (i >= n && i < m) begin
                rd = {rd[6:0], vdio_line};
            end
            #24 vclk = 1'b0;
        end
        drv_en = 1'b0;
    endtask : xfer
endmodule : link_master

// ---- power_alarm_checker.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module power_alarm_checker #(
    parameter int UPDATE_CYCLES = 20000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic vclk,
    input wire logic vdio_oe,
    input wire logic alert_out,
    input wire logic alert_oe,
    input wire logic alarm_out,
    input wire logic alarm_oe,
    input wire power_alarm_pkg::adc_req_s adc_req
);
    import power_alarm_pkg::*;
    int gap;
    logic seen;
    logic last_chan;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // gap counts cycles since the last converter start
    always_ff @(posedge mclk) begin
        if (rst || adc_req.start) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            seen <= 1'b0;
        end else if (adc_req.start) begin
            seen <= 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (adc_req.start) begin
            last_chan <= adc_req.chan;
        end
    end
    quiet_reset_a: assert property ($fell(rst) |->
        !alarm_oe && !alert_oe && !vdio_oe && !adc_req.start)
        else $error("outputs active right after reset");
    alarm_pin_a: assert property (alarm_out == 1'b0)
        else $error("alarm pin driven high");
    alert_pin_a: assert property (alert_out == 1'b0)
        else $error("alert pin driven high");
    start_pulse_a: assert property (adc_req.start |=> !adc_req.start)
        else $error("converter start longer than one cycle");
    chan_swap_a: assert property (adc_req.start && seen |->
        adc_req.chan != last_chan) else $error("channel not alternated");
    sample_gap_a: assert property (seen |-> gap < UPDATE_CYCLES / 2)
        else $error("converter start overdue");
    drive_start_a: assert property ($rose(vdio_oe) |-> !vclk)
        else $error("data drive began with link clock high");
    drive_hold_a: assert property ($rose(vdio_oe) |-> vdio_oe [*3])
        else $error("data drive too short");
    drive_end_a: assert property ($fell(vdio_oe) |-> vclk)
        else $error("data drive released with link clock low");
endmodule : power_alarm_checker

bind dual_channel_power_alarm_regs power_alarm_checker #(
    .UPDATE_CYCLES(UPDATE_CYCLES)
) i_power_alarm_checker (.mclk(mclk), .rst(rst), .vclk(vclk),
    .vdio_oe(vdio_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .adc_req(adc_req));

// ---- power_alarm_pkg.sv ----
package power_alarm_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MAKER = 8'h00;
    localparam logic [7:0] OFS_PART = 8'h01;
    localparam logic [7:0] OFS_REV = 8'h02;
    localparam logic [7:0] OFS_PROTO = 8'h05;
    localparam logic [7:0] OFS_CAPS = 8'h06;
    localparam logic [7:0] OFS_GAIN_CH1 = 8'h07;
    localparam logic [7:0] OFS_GAIN_CH2 = 8'h08;
    localparam logic [7:0] OFS_POWER_READING_CH1 = 8'h09;
    localparam logic [7:0] OFS_POWER_READING_CH2 = 8'h0a;
    localparam logic [7:0] OFS_THRESH_CH1 = 8'h0b;
    localparam logic [7:0] OFS_THRESH_CH2 = 8'h0c;
    localparam logic [7:0] OFS_CFG_CH1 = 8'h0d;
    localparam logic [7:0] OFS_CFG_CH2 = 8'h0e;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_LAST_GET = 8'h14;
    localparam logic [7:0] OFS_STATUS_SNAP = 8'h1c;
    localparam logic [7:0] OFS_WLVL_CH1 = 8'h4b;
    localparam logic [7:0] OFS_WLVL_CH2 = 8'h4c;
    localparam logic [7:0] OFS_WCNT_CH1 = 8'h4d;
    localparam logic [7:0] OFS_WCNT_CH2 = 8'h4e;
    localparam logic [7:0] OFS_GAIN_BOTH = 8'hc0;
    localparam logic [7:0] OFS_CFG_BOTH = 8'hc1;

    // ------------------------------------------------------------
    // reset values and fixed contents
    // ------------------------------------------------------------
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'he6;
    localparam logic [7:0] RST_CFG = 8'h03;
    localparam logic [7:0] VAL_PROTO = 8'h12;
    localparam logic [7:0] VAL_CAPS = 8'h20;
    localparam logic [7:0] ZERO8 = 8'h00;

    // ------------------------------------------------------------
    // field layout and codes
    // ------------------------------------------------------------
    localparam logic [3:0] GAIN_CODE_X2 = 4'h3;
    localparam logic [3:0] GAIN_CODE_X8 = 4'hf;
    localparam logic [1:0] HYST_10 = 2'h2;
    localparam logic [1:0] HYST_15 = 2'h3;
    localparam int CFG_ALERT_MASK = 2;
    localparam logic [7:0] WARN_MAX = 8'hff;
    localparam logic [3:0] BASE_ADDR = 4'h8;
    localparam int ST_ALARM1 = 0;
    localparam int ST_ALARM2 = 1;
    localparam int ST_ALERT = 2;
    localparam int ST_VALID = 3;

    // ------------------------------------------------------------
    // link framing
    // ------------------------------------------------------------
    localparam logic [4:0] HDR_BITS = 5'd13;
    localparam logic [4:0] BYTE_BITS = 5'd8;
    localparam logic [4:0] ACK_BITS = 5'd1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int PWRUP_US = 80;
    localparam int UPDATE_US = 80;
    localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
    localparam int UPDATE_CYC = UPDATE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_DATA = 2'b10,
        ST_RESP = 2'b11
    } link_state_e;

    typedef struct packed {
        logic start;
        logic chan;
    } adc_req_s;

    typedef struct packed {
        logic done;
        logic chan;
        logic [7:0] code;
    } adc_res_s;

endpackage : power_alarm_pkg

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module tb_top;
    import power_alarm_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr_strap = 2'b00;
    logic [1:0] gain_strap_pin = 2'b01;
    logic [1:0] gain_is_x8;
    logic vclk, vdio_line, vdio_out, vdio_oe;
    logic alert_out, alert_oe, alarm_out, alarm_oe;
    logic [3:0] me;
    logic [7:0] rd;
    adc_req_s adc_req;
    adc_res_s adc_res = '0;
    logic [7:0] code [2] = '{8'h00, 8'h42};
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    assign me = {2'b10, addr_strap};
    always #2 mclk = ~mclk;
    dual_channel_power_alarm_regs #(.PWRUP_CYCLES(2000), .UPDATE_CYCLES(40))
    i_dual_channel_power_alarm_regs (.mclk(mclk), .rst(rst), .vclk(vclk),
        .vdio_in(vdio_line), .vdio_out(vdio_out), .vdio_oe(vdio_oe),
        .alert_out(alert_out), .alert_oe(alert_oe), .alarm_out(alarm_out),
        .alarm_oe(alarm_oe), .addr_strap(addr_strap),
        .gain_strap_pin(gain_strap_pin), .gain_is_x8(gain_is_x8),
        .adc_req(adc_req), .adc_res(adc_res));
    link_master i_link_master (.vdio_out(vdio_out), .vdio_oe(vdio_oe),
        .vclk(vclk), .vdio_line(vdio_line));
    // converter answers one cycle after each start; also the hang limit
    always @(posedge mclk) begin
        #1;
        if (adc_req.start) adc_res = '{1'b1, adc_req.chan, code[adc_req.chan]};
        else adc_res = '0;
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic rw(input logic [3:0] a, input logic g,
        input logic [7:0] idx, input logic [7:0] wd);
        @(posedge mclk);
        #1 i_link_master.xfer(a, g, idx, wd, rd);
    endtask : rw
    task automatic settle(input logic [7:0] c, input logic want);
        @(posedge mclk);
        #1 code[0] = c;
        repeat (50) @(posedge mclk);
        `CHK(alarm_oe, want)
    endtask : settle
    task automatic t_reset_vals;
        logic [7:0] ofs [8] = '{OFS_POWER_READING_CH1, OFS_THRESH_CH1, OFS_THRESH_CH2,
            OFS_CFG_CH1, OFS_CFG_BOTH, OFS_WLVL_CH2, OFS_GAIN_BOTH, OFS_PROTO};
        logic [7:0] want [8] = '{ZERO8, RST_THRESH, RST_THRESH, RST_CFG,
            8'h33, 8'((RST_THRESH * 10'd3) >> 2), RST_GAIN, VAL_PROTO};
        for (int i = 0; i < 8; i++) begin
            rw(me, 1'b1, ofs[i], 8'h00);
            `CHK(rd, want[i])
        end
        `CHK(gain_is_x8, 2'b10)
        $display("reset values done");
    endtask : t_reset_vals
    task automatic t_address;
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            #1 addr_strap = 2'(s);
            repeat (4) @(posedge mclk);
            rw(me, 1'b1, OFS_CAPS, 8'h00);
            `CHK(rd, VAL_CAPS)
            rw(me ^ 4'h1, 1'b1, OFS_CAPS, 8'h00);
            `CHK(rd, 8'hff)
        end
        $display("address straps done");
    endtask : t_address
    task automatic t_gain;
        rw(me, 1'b0, OFS_GAIN_CH1, 8'h03);
        `CHK(gain_is_x8, 2'b10)
        rw(me, 1'b0, OFS_GAIN_CH1, 8'h0f);
        `CHK(gain_is_x8, 2'b11)
        rw(me, 1'b0, OFS_GAIN_BOTH, 8'h3f);
        `CHK(gain_is_x8, 2'b01)
        rw(me, 1'b1, OFS_GAIN_CH2, 8'h00);
        `CHK(rd, 8'h03)
        rw(me, 1'b0, OFS_GAIN_BOTH, 8'h00);
        `CHK(gain_is_x8, 2'b10)
        rw(me, 1'b0, 8'h33, 8'h00);
        `CHK(rd, 8'h01)
        $display("gain select done");
    endtask : t_gain
    task automatic t_alarm;
        rw(me, 1'b0, OFS_THRESH_CH1, 8'h80);
        rw(me, 1'b1, OFS_WLVL_CH1, 8'h00);
        `CHK(rd, 8'h60)
        settle(8'h80, 1'b0);
        settle(8'h81, 1'b1);
        rw(me, 1'b1, OFS_STATUS, 8'h00);
        rw(me, 1'b1, OFS_LAST_GET, 8'h00);
        `CHK(rd, 8'h09)
        rw(me, 1'b1, OFS_STATUS_SNAP, 8'h00);
        `CHK(rd, 8'h09)
        rw(me, 1'b0, OFS_POWER_READING_CH1, 8'h55);
        rw(me, 1'b1, OFS_POWER_READING_CH1, 8'h00);
        `CHK(rd, 8'h81)
        rw(me, 1'b1, OFS_POWER_READING_CH2, 8'h00);
        `CHK(rd, 8'h42)
        settle(8'h6d, 1'b1);
        settle(8'h6c, 1'b0);
        rw(me, 1'b0, OFS_CFG_CH1, 8'h02);
        settle(8'h81, 1'b1);
        settle(8'h74, 1'b1);
        settle(8'h73, 1'b0);
        rw(me, 1'b0, OFS_CFG_CH1, 8'h01);
        settle(8'h81, 1'b1);
        settle(8'h7f, 1'b0);
        $display("alarm done");
    endtask : t_alarm
    task automatic t_alert;
        settle(8'h81, 1'b1);
        repeat (10300) @(posedge mclk);
        `CHK(alert_oe, 1'b1)
        rw(me, 1'b0, OFS_CFG_BOTH, 8'h37);
        `CHK(alert_oe, 1'b0)
        settle(8'h00, 1'b0);
        rw(me, 1'b1, OFS_WCNT_CH1, 8'h00);
        `CHK(rd, WARN_MAX)
        rw(me, 1'b1, OFS_WCNT_CH1, 8'h00);
        `CHK(rd, ZERO8)
        $display("alert done");
    endtask : t_alert
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        t_reset_vals();
        t_address();
        t_gain();
        t_alarm();
        t_alert();
        finish_test();
    end
endmodule : tb_top
